// >>> src/central_arith_unit.sv
`timescale 1ns/1ps
// Notes on behaviour
// - load, add, subtract shift the data word left by zero through sixteen
// - input shift count comes from the instruction, not a register
// - input shifter takes 16-bit data and yields 32 bits to the ALU
// - input shift zero-fills low bits and sign-extends to 32 bits
// - unsigned add/subtract use the word zero-extended, no sign extension
// - ALU operand A is always the sum register; B is product, shifter or the zero-extended word
// - provides 32-bit ALU, 32-bit sum register, 16x16 multiplier
// - fetch, input shift, ALU into sum register, output shift, store halves
// - output shifter only on store high word; keeps upper 16 bits
// - output shift amounts are zero, one or four only
// - storing through the output shifter leaves the sum register unchanged
// - no right shift in either shifter
// - vacated low bits of stored high word come from the low word
module central_arith_unit #(
   parameter int DATA_W = arith_pkg::DATA_W,
   parameter int ACC_W  = arith_pkg::ACC_W
) (
   input  wire logic                            CORE_CLK_I,
   input  wire logic                            RST_I,
   input  wire logic                            OP_VALID_I,
   input  wire arith_pkg::alu_op_t              OP_I,
   input  wire logic [arith_pkg::ISH_CNT_W-1:0] IN_SHIFT_I,
   input  wire logic [arith_pkg::OSH_SEL_W-1:0] OUT_SHIFT_I,
   input  wire logic [DATA_W-1:0]               DATA_I,
   input  wire logic                            SAT_MODE_I,
   output logic      [ACC_W-1:0]                SUM_REGISTER_O,
   output logic      [ACC_W-1:0]                PRODUCT_O,
   output logic      [DATA_W-1:0]               STORE_DATA_O,
   output logic                                 STORE_VALID_O,
   output logic                                 OVERFLOW_O
);
   logic [ACC_W-1:0]  sum_register_q;
   logic [ACC_W-1:0]  sum_register_d;
   logic [ACC_W-1:0]  product_q;
   logic [DATA_W-1:0] mult_operand_q;
   logic [DATA_W-1:0] store_data_q;
   logic              store_valid_q;
   logic              overflow_q;

   logic [arith_pkg::ISH_CNT_W-1:0] shift_cnt;
   logic [ACC_W-1:0]  ext_word;
   logic [ACC_W-1:0]  shifted_word;
   logic [ACC_W-1:0]  unsigned_word;
   logic [ACC_W-1:0]  operand_b;
   logic [ACC_W-1:0]  logic_word;
   logic              use_product;
   logic              use_unsigned;
   logic              is_sub;
   logic              is_arith;
   logic              is_logic;
   logic [ACC_W-1:0]  add_res;
   logic [ACC_W-1:0]  logic_res;
   logic              arith_ovf;
   logic [ACC_W-1:0]  sat_res;
   logic [ACC_W-1:0]  product_d;
   logic [DATA_W-1:0] high_store_word;
   logic              is_store_high;
   logic              is_store_low;
   logic              writes_sum;

   initial
   begin
      if (ACC_W != 2 * DATA_W)
      begin
         $error("central_arith_unit: accumulator must be twice the data width");
      end
      if (DATA_W != arith_pkg::HALF_HI)
      begin
         $error("central_arith_unit: shift range is fixed to a 16-bit data word");
      end
   end

   // counts above sixteen clamp to sixteen; count comes with the op
   assign shift_cnt = (IN_SHIFT_I > arith_pkg::ISH_CNT_W'(arith_pkg::ISH_MAX)) ?
                      arith_pkg::ISH_CNT_W'(arith_pkg::ISH_MAX) : IN_SHIFT_I;

   // 16-bit in, 32-bit out, arithmetic extension then left shift only
   assign ext_word     = {{(ACC_W-DATA_W){DATA_I[DATA_W-1]}}, DATA_I};
   assign shifted_word = ext_word << shift_cnt;

   // unsigned variants: upper bits zero
   assign unsigned_word = {{(ACC_W-DATA_W){1'b0}}, DATA_I};
   assign logic_word    = {{(ACC_W-DATA_W){1'b0}}, DATA_I};

   assign use_product  = (OP_I == arith_pkg::OP_LOAD_PRODUCT) ||
                         (OP_I == arith_pkg::OP_ADD_PRODUCT) ||
                         (OP_I == arith_pkg::OP_SUB_PRODUCT);
   assign use_unsigned = (OP_I == arith_pkg::OP_ADD_UNSIGNED_LOW) ||
                         (OP_I == arith_pkg::OP_SUBTRACT_UNSIGNED_LOW);
   assign is_sub       = (OP_I == arith_pkg::OP_SUB) ||
                         (OP_I == arith_pkg::OP_SUBTRACT_UNSIGNED_LOW) ||
                         (OP_I == arith_pkg::OP_SUB_PRODUCT);
   assign is_arith     = (OP_I == arith_pkg::OP_ADD) || (OP_I == arith_pkg::OP_SUB) ||
                         use_unsigned ||
                         (OP_I == arith_pkg::OP_ADD_PRODUCT) ||
                         (OP_I == arith_pkg::OP_SUB_PRODUCT);
   assign is_logic     = (OP_I == arith_pkg::OP_AND) || (OP_I == arith_pkg::OP_OR) ||
                         (OP_I == arith_pkg::OP_XOR);

   // second operand: product register, zero-extended unsigned word or input shifter
   assign operand_b = use_product  ? product_q :
                      use_unsigned ? unsigned_word : shifted_word;

   // first operand always the sum register
   assign add_res = is_sub ? (sum_register_q - operand_b) :
                             (sum_register_q + operand_b);

   assign arith_ovf = is_sub ?
      ((sum_register_q[ACC_W-1] != operand_b[ACC_W-1]) &&
       (add_res[ACC_W-1] != sum_register_q[ACC_W-1])) :
      ((sum_register_q[ACC_W-1] == operand_b[ACC_W-1]) &&
       (add_res[ACC_W-1] != sum_register_q[ACC_W-1]));

   // saturation picks the limit from the first operand's sign
   assign sat_res = (arith_ovf && SAT_MODE_I) ?
                    (sum_register_q[ACC_W-1] ? arith_pkg::SAT_NEG : arith_pkg::SAT_POS) :
                    add_res;

   // logical ops: zero against the upper half
   assign logic_res = (OP_I == arith_pkg::OP_AND) ? (sum_register_q & logic_word) :
                      (OP_I == arith_pkg::OP_OR)  ? (sum_register_q | logic_word) :
                                                    (sum_register_q ^ logic_word);

   // 16x16 signed product
   assign product_d = ACC_W'($signed(mult_operand_q) * $signed(DATA_I));

   assign is_store_high = (OP_I == arith_pkg::OP_STORE_HIGH_WORD);
   assign is_store_low  = (OP_I == arith_pkg::OP_STORE_LOW_WORD);
   assign writes_sum    = OP_VALID_I && (is_arith || is_logic ||
                          (OP_I == arith_pkg::OP_LOAD_SUM_REGISTER) ||
                          (OP_I == arith_pkg::OP_LOAD_PRODUCT));

   assign sum_register_d =
      (OP_I == arith_pkg::OP_LOAD_SUM_REGISTER) ? shifted_word :
      (OP_I == arith_pkg::OP_LOAD_PRODUCT)      ? product_q :
      is_logic                                  ? logic_res : sat_res;

   store_shifter #(
      .ACC_W  (ACC_W),
      .DATA_W (DATA_W)
   ) i_store_shifter (
      .acc_i  (sum_register_q),
      .sel_i  (OUT_SHIFT_I),
      .word_o (high_store_word)
   );

   // stores never write the sum register
   always_ff @(posedge CORE_CLK_I)
   begin
      if (RST_I)
      begin
         sum_register_q <= arith_pkg::ACC_RESET;
      end
      else if (writes_sum)
      begin
         sum_register_q <= sum_register_d;
      end
   end

   always_ff @(posedge CORE_CLK_I)
   begin
      if (RST_I)
      begin
         product_q      <= arith_pkg::ACC_RESET;
         mult_operand_q <= '0;
      end
      else if (OP_VALID_I && OP_I == arith_pkg::OP_LOAD_MULT_OPERAND)
      begin
         mult_operand_q <= DATA_I;
      end
      else if (OP_VALID_I && OP_I == arith_pkg::OP_MULTIPLY)
      begin
         product_q <= product_d;
      end
   end

   // each half leaves as its own store
   always_ff @(posedge CORE_CLK_I)
   begin
      if (RST_I)
      begin
         store_data_q  <= '0;
         store_valid_q <= 1'b0;
      end
      else
      begin
         store_valid_q <= OP_VALID_I && (is_store_high || is_store_low);
         if (OP_VALID_I && is_store_high)
         begin
            store_data_q <= high_store_word;
         end
         else if (OP_VALID_I && is_store_low)
         begin
            store_data_q <= sum_register_q[arith_pkg::HALF_LO +: DATA_W];
         end
      end
   end

   // overflow is sticky until reset
   always_ff @(posedge CORE_CLK_I)
   begin
      if (RST_I)
      begin
         overflow_q <= 1'b0;
      end
      else if (OP_VALID_I && is_arith && arith_ovf)
      begin
         overflow_q <= 1'b1;
      end
   end

   assign SUM_REGISTER_O = sum_register_q;
   assign PRODUCT_O      = product_q;
   assign STORE_DATA_O   = store_data_q;
   assign STORE_VALID_O  = store_valid_q;
   assign OVERFLOW_O     = overflow_q;
endmodule

// >>> src/arith_pkg.sv
package arith_pkg;
   localparam int DATA_W     = 16;
   localparam int ACC_W      = 32;
   localparam int ISH_CNT_W  = 5;
   localparam int ISH_MAX    = 16;
   localparam int OSH_SEL_W  = 2;
   localparam int HALF_LO    = 0;
   localparam int HALF_HI    = 16;

   localparam logic [ACC_W-1:0] ACC_RESET = 32'h0000_0000;
   localparam logic [ACC_W-1:0] SAT_POS   = 32'h7FFF_FFFF;
   localparam logic [ACC_W-1:0] SAT_NEG   = 32'h8000_0000;

   // output shift selects
   localparam logic [OSH_SEL_W-1:0] OSH_0 = 2'h0;
   localparam logic [OSH_SEL_W-1:0] OSH_1 = 2'h1;
   localparam logic [OSH_SEL_W-1:0] OSH_4 = 2'h2;

   typedef enum logic [3:0] {
      OP_NOP                   = 4'h0,
      OP_LOAD_SUM_REGISTER     = 4'h1,
      OP_ADD                   = 4'h2,
      OP_SUB                   = 4'h3,
      OP_ADD_UNSIGNED_LOW      = 4'h4,
      OP_SUBTRACT_UNSIGNED_LOW = 4'h5,
      OP_LOAD_PRODUCT          = 4'h6,
      OP_ADD_PRODUCT           = 4'h7,
      OP_SUB_PRODUCT           = 4'h8,
      OP_AND                   = 4'h9,
      OP_OR                    = 4'hA,
      OP_XOR                   = 4'hB,
      OP_MULTIPLY              = 4'hC,
      OP_LOAD_MULT_OPERAND     = 4'hD,
      OP_STORE_HIGH_WORD       = 4'hE,
      OP_STORE_LOW_WORD        = 4'hF
   } alu_op_t;
endpackage

// >>> src/store_shifter.sv
`timescale 1ns/1ps
module store_shifter #(
   parameter int ACC_W  = arith_pkg::ACC_W,
   parameter int DATA_W = arith_pkg::DATA_W
) (
   input  wire logic [ACC_W-1:0]               acc_i,
   input  wire logic [arith_pkg::OSH_SEL_W-1:0] sel_i,
   output logic      [DATA_W-1:0]              word_o
);
   logic [ACC_W-1:0] shifted;

   initial
   begin
      if (ACC_W != 2 * DATA_W)
      begin
         $error("store_shifter: accumulator must be twice the data width");
      end
   end

   // unsupported codes fall back to no shift
   assign shifted = (sel_i == arith_pkg::OSH_1) ? (acc_i << 1) :
                    (sel_i == arith_pkg::OSH_4) ? (acc_i << 4) :
                    acc_i;

   // top word kept; low-word bits move up into the vacated positions
   assign word_o = shifted[ACC_W-1 -: DATA_W];
endmodule

// >>> verification/central_arith_unit_sva.sv
`timescale 1ns/1ps
module central_arith_unit_sva #(
   parameter int DATA_W = 16,
   parameter int ACC_W  = 32
) (
   input wire logic                            CORE_CLK_I,
   input wire logic                            RST_I,
   input wire logic                            OP_VALID_I,
   input wire arith_pkg::alu_op_t              OP_I,
   input wire logic [arith_pkg::ISH_CNT_W-1:0] IN_SHIFT_I,
   input wire logic [arith_pkg::OSH_SEL_W-1:0] OUT_SHIFT_I,
   input wire logic [DATA_W-1:0]               DATA_I,
   input wire logic [ACC_W-1:0]                SUM_REGISTER_O,
   input wire logic [DATA_W-1:0]               STORE_DATA_O,
   input wire logic                            STORE_VALID_O
);
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (RST_I);
   wire logic hi = OP_VALID_I && OP_I == arith_pkg::OP_STORE_HIGH_WORD;
   wire logic lo = OP_VALID_I && OP_I == arith_pkg::OP_STORE_LOW_WORD;
   wire logic ld = OP_VALID_I && OP_I == arith_pkg::OP_LOAD_SUM_REGISTER;
   a_store_pulse: assert property (hi |=> STORE_VALID_O ##1
      STORE_VALID_O == $past(hi || lo))
      else $error("store pulse wrong");
   a_store_keeps_sum: assert property ((hi || lo) |=> $stable(SUM_REGISTER_O))
      else $error("store changed sum");
   a_high_no_shift: assert property (hi && OUT_SHIFT_I == 2'h0 |=> STORE_DATA_O == $past(SUM_REGISTER_O[31:16]))
      else $error("high word wrong");
   a_high_shift_one: assert property (hi && OUT_SHIFT_I == 2'h1 |=> STORE_DATA_O == $past(SUM_REGISTER_O[30:15]))
      else $error("shift one wrong");
   a_high_shift_four: assert property (hi && OUT_SHIFT_I == 2'h2 |=> STORE_DATA_O == $past(SUM_REGISTER_O[27:12]))
      else $error("shift four wrong");
   a_bad_select_zero: assert property (hi && OUT_SHIFT_I == 2'h3 |=> STORE_DATA_O == $past(SUM_REGISTER_O[31:16]))
      else $error("spare select shifted");
   a_low_word_plain: assert property (lo |=> STORE_DATA_O == $past(SUM_REGISTER_O[15:0]) && STORE_VALID_O)
      else $error("low word wrong");
   a_load_sign_ext: assert property (ld && IN_SHIFT_I == 5'h00 |=> SUM_REGISTER_O == {{16{$past(DATA_I[15])}}, $past(DATA_I)})
      else $error("load extension wrong");
   a_load_max_shift: assert property (ld && IN_SHIFT_I >= 5'h10 |=> SUM_REGISTER_O == {$past(DATA_I), 16'h0000})
      else $error("load sixteen wrong");
   a_unsigned_add: assert property (OP_VALID_I && OP_I == arith_pkg::OP_ADD_UNSIGNED_LOW |=> SUM_REGISTER_O == $past(SUM_REGISTER_O) + {16'h0000, $past(DATA_I)})
      else $error("unsigned add wrong");
endmodule
bind central_arith_unit central_arith_unit_sva #(.DATA_W(DATA_W), .ACC_W(ACC_W)) i_central_arith_unit_sva (
   .CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .OP_VALID_I(OP_VALID_I), .OP_I(OP_I),
   .IN_SHIFT_I(IN_SHIFT_I), .OUT_SHIFT_I(OUT_SHIFT_I), .DATA_I(DATA_I),
   .SUM_REGISTER_O(SUM_REGISTER_O), .STORE_DATA_O(STORE_DATA_O), .STORE_VALID_O(STORE_VALID_O));

// >>> verification/central_arith_unit_shift_datapath_tb.sv
`timescale 1ns/1ps
module central_arith_unit_shift_datapath_tb;
   typedef struct packed {logic [15:0] w; logic [31:0] a; logic [31:0] m; logic v;} note_t;
   logic               fl;
   logic               clk, rst, vld, sat, st_v, ovf;
   arith_pkg::alu_op_t op;
   logic [4:0]         ish;
   logic [1:0]         osh;
   logic [15:0]        din, st_d, t;
   logic [31:0]        sum, prod, acc, p;
   note_t              q[$];
   note_t              n;
   int                 fails, checked, seed, i;
   central_arith_unit i_central_arith_unit (
      .CORE_CLK_I(clk), .RST_I(rst), .OP_VALID_I(vld), .OP_I(op), .IN_SHIFT_I(ish),
      .OUT_SHIFT_I(osh), .DATA_I(din), .SAT_MODE_I(sat), .SUM_REGISTER_O(sum),
      .PRODUCT_O(prod), .STORE_DATA_O(st_d), .STORE_VALID_O(st_v), .OVERFLOW_O(ovf));
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task cmp_word(input logic [15:0] e, input logic [15:0] s);
      checked++;
      if (s !== e)
      begin
         fails++;
         $display("mismatch store word expected %h seen %h", e, s);
      end
   endtask
   task cmp_sum(input logic [31:0] e, input logic [31:0] s);
      checked++;
      if (s !== e)
      begin
         fails++;
         $display("mismatch sum register expected %h seen %h", e, s);
      end
   endtask
   task cmp_prod(input logic [31:0] e, input logic [31:0] s);
      checked++;
      if (s !== e)
      begin
         fails++;
         $display("mismatch product register expected %h seen %h", e, s);
      end
   endtask
   task cmp_flag(input logic e, input logic s);
      checked++;
      if (s !== e)
      begin
         fails++;
         $display("mismatch overflow flag expected %b seen %b", e, s);
      end
   endtask
   // result of an arithmetic op; notes a signed overflow and saturates if asked
   function automatic logic [31:0] arith(input logic [31:0] b, input logic s);
      logic [32:0] r;
      r = s ? ({acc[31], acc} - {b[31], b}) : ({acc[31], acc} + {b[31], b});
      if (r[32] != r[31])
      begin
         fl = 1'b1;
         if (sat)
            return r[32] ? arith_pkg::SAT_NEG : arith_pkg::SAT_POS;
      end
      return r[31:0];
   endfunction
   task stop_test;
      if (q.size() != 0)
      begin
         fails++;
         $display("mismatch pending stores expected 0 seen %0d", q.size());
      end
      if (fails == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task drive(input arith_pkg::alu_op_t o, input logic [15:0] d, input logic [4:0] s,
              input logic [1:0] h);
      logic [31:0] x, z, y;
      x = {{16{d[15]}}, d} << ((s > 5'h10) ? 5'h10 : s);
      z = {16'h0000, d};
      y = acc << ((h == 2'h1) ? 1 : (h == 2'h2) ? 4 : 0);
      @(posedge clk);
      vld <= 1'b1;
      op <= o;
      din <= d;
      ish <= s;
      osh <= h;
      case (o)
         arith_pkg::OP_LOAD_SUM_REGISTER:     acc = x;
         arith_pkg::OP_ADD:                   acc = arith(x, 1'b0);
         arith_pkg::OP_SUB:                   acc = arith(x, 1'b1);
         arith_pkg::OP_ADD_UNSIGNED_LOW:      acc = arith(z, 1'b0);
         arith_pkg::OP_SUBTRACT_UNSIGNED_LOW: acc = arith(z, 1'b1);
         arith_pkg::OP_LOAD_PRODUCT:          acc = p;
         arith_pkg::OP_ADD_PRODUCT:           acc = arith(p, 1'b0);
         arith_pkg::OP_SUB_PRODUCT:           acc = arith(p, 1'b1);
         arith_pkg::OP_AND:                   acc = acc & z;
         arith_pkg::OP_OR:                    acc = acc | z;
         arith_pkg::OP_XOR:                   acc = acc ^ z;
         arith_pkg::OP_LOAD_MULT_OPERAND:     t = d;
         arith_pkg::OP_MULTIPLY:              p = {{16{t[15]}}, t} * {{16{d[15]}}, d};
         arith_pkg::OP_STORE_HIGH_WORD:       q.push_back({y[31:16], acc, p, fl});
         arith_pkg::OP_STORE_LOW_WORD:        q.push_back({acc[15:0], acc, p, fl});
         default:                             ;
      endcase
   endtask
   task idle;
      @(posedge clk);
      vld <= 1'b0;
      op <= arith_pkg::alu_op_t'(4'($random(seed)));
      din <= 16'($random(seed));
   endtask
   always @(posedge clk)
      if (st_v === 1'b1)
      begin
         n = q.pop_front();
         cmp_word(n.w, st_d);
         cmp_sum(n.a, sum);
         cmp_prod(n.m, prod);
         cmp_flag(n.v, ovf);
      end
   initial
   begin
      #25000;
      fails++;
      stop_test;
   end
   initial
   begin
      seed = 32'h7FB3B441;
      rst = 1'b1;
      vld = 1'b0;
      sat = 1'b0;
      op = arith_pkg::OP_NOP;
      {ish, osh, din, acc, p, t, fl} = '0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      cmp_sum(32'h0000_0000, sum);
      drive(arith_pkg::OP_LOAD_SUM_REGISTER, 16'h7EBC, 5'h04, 2'h0);
      drive(arith_pkg::OP_STORE_HIGH_WORD, 16'h0000, 5'h00, 2'h0);
      drive(arith_pkg::OP_LOAD_SUM_REGISTER, 16'hA34B, 5'h10, 2'h0);
      drive(arith_pkg::OP_OR, 16'h78CD, 5'h00, 2'h0);
      drive(arith_pkg::OP_STORE_HIGH_WORD, 16'h0000, 5'h00, 2'h2);
      drive(arith_pkg::OP_STORE_HIGH_WORD, 16'h0000, 5'h00, 2'h1);
      drive(arith_pkg::OP_STORE_LOW_WORD, 16'h0000, 5'h00, 2'h3);
      // saturation both ways, then a reset in mid-run clears the sticky flag
      sat <= 1'b1;
      drive(arith_pkg::OP_LOAD_SUM_REGISTER, 16'h7FFF, 5'h10, 2'h0);
      drive(arith_pkg::OP_ADD, 16'h7FFF, 5'h10, 2'h0);
      drive(arith_pkg::OP_STORE_HIGH_WORD, 16'h0000, 5'h00, 2'h0);
      drive(arith_pkg::OP_LOAD_SUM_REGISTER, 16'h8000, 5'h10, 2'h0);
      drive(arith_pkg::OP_SUB, 16'h0001, 5'h10, 2'h0);
      drive(arith_pkg::OP_STORE_LOW_WORD, 16'h0000, 5'h00, 2'h0);
      idle;
      sat <= 1'b0;
      repeat (2) @(posedge clk);
      rst <= 1'b1;
      {acc, p, t, fl} = '0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      cmp_sum(32'h0000_0000, sum);
      cmp_prod(32'h0000_0000, prod);
      cmp_flag(1'b0, ovf);
      for (i = 0; i < 600; i++)
      begin
         drive(arith_pkg::alu_op_t'(4'($random(seed))), 16'($random(seed)),
               5'($random(seed)), 2'($random(seed)));
         if ($random(seed) % 4 == 0)
            idle;
      end
      idle;
      repeat (3) @(posedge clk);
      stop_test;
   end
endmodule
